// >>> light_sensor_measure_control.sv
// Light and flicker measure control register bank with run control
//
// Contract
// RQ1: Bits 2..0 of modulator control switch off modulators 2,1,0; reset zero.
// RQ2: Writing enable bit 6 starts flicker detection; zero stops it; resets zero.
// RQ3: Writing enable bit 1 starts light measurement; zero stops it; resets zero.
// RQ4: Oscillator runs while power-on bit 0 is set, else stays off.
// RQ5: Writing power-on zero stops oscillator and clears both measurement enables.
// RQ6: Host should set power-on last, after all other configuration.
// RQ7: Stop-after-count clears both enables after set iterations; power-on stays.
// RQ8: Double-step bit makes saturation drop gain two steps when above zero; code drops one step from gain one.
// RQ9: Single-shot bit runs one measurement cycle, then enters sleep-after-interrupt.
// RQ10: Light status bit writes a status word to FIFO with light data.
// RQ11: Four-bit scale field, reset 4, leading zeros needed for scaled result.
// RQ12: Internal light result up to 26 bits, reduced by top-bit position.
// RQ13: End-marker bit writes end marker after each complete flicker measurement.
// RQ14: Checksum bit writes flicker checksum after each complete flicker measurement.
// RQ15: Gain-write bit writes gain after each flicker measurement; needed with AGC.
// RQ16: Five-bit top-bit field, reset 12, picks MSB in 32-bit result.
// RQ17: Endless flicker repeat writes continuously and inserts no end markers.
// RQ18: Sample step counts modulator clocks of 1.388889us times sample-time plus one; code uses 27 core clocks of 50ns, 1.35us.
// RQ19: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`include "light_sensor_consts.svh"
`default_nettype none

module light_sensor_measure_control
  import light_sensor_pkg::*;
#(
  parameter int ITER_COUNT = 1,
  parameter int RESULT_WIDTH = 32,
  parameter logic [3:0] GAIN_STEP_RESET = 4'h9
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [10:0] sample_time,
  input wire logic flicker_endless_repeat,
  input wire logic meas_done,
  input wire logic light_done,
  input wire logic flicker_done,
  input wire logic [RESULT_WIDTH-1:0] raw_result,
  input wire logic gain_saturate,
  input wire logic [11:0] flicker_checksum,
  output logic osc_run_q,
  output logic [2:0] modulator_on_q,
  output logic flicker_enable_q,
  output logic light_measure_enable_q,
  output logic sleep_after_irq_q,
  output logic sample_step_q,
  output logic [15:0] light_data_q,
  output logic light_scaled_q,
  output logic [3:0] gain_step_q,
  output logic fifo_wr_q,
  output logic [15:0] fifo_word_q
);

  localparam logic [4:0] MOD_DIV_LAST = 5'(`MOD_PERIOD_CYC - 1);
  localparam logic [7:0] ITER_LAST = 8'(ITER_COUNT - 1);

  logic [2:0] mod_off_q;
  logic power_on_bit_q;
  logic [7:0] mode_first_q;
  logic [7:0] mode_second_q;
  run_state_e run_q;
  run_state_e run_d;
  logic [7:0] iter_q;
  logic [4:0] mod_div_q;
  logic mod_tick;
  logic [10:0] step_cnt_q;
  logic [4:0] pending_q;
  logic [4:0] pending_d;
  logic [15:0] scaled_data;
  logic scaled_flag;
  logic wr_mod;
  logic wr_enable;
  logic wr_first;
  logic wr_second;
  logic halt_now;

  // Address decode, used by the write and read paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  assign wr_mod = reg_wr && hit(reg_addr, `OFS_MOD_DISABLE);
  assign wr_enable = reg_wr && hit(reg_addr, `OFS_ENABLE);
  assign wr_first = reg_wr && hit(reg_addr, `OFS_MODE_FIRST);
  assign wr_second = reg_wr && hit(reg_addr, `OFS_MODE_SECOND);

  // Modulator disable bits, upper bits ignored
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mod_off_q <= 3'(`RST_MOD_DISABLE);
    end else if (wr_mod) begin
      mod_off_q <= reg_wdata[2:0]; // RQ1 RQ19
    end
  end

  // Modulator run outputs follow disable bits and oscillator
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      modulator_on_q <= 3'b000;
    end else begin
      modulator_on_q <= {3{power_on_bit_q}} & ~mod_off_q; // RQ1 RQ4
    end
  end

  // Power-on bit and oscillator run
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      power_on_bit_q <= 1'b0;
      osc_run_q <= 1'b0;
    end else begin
      if (wr_enable) begin
        power_on_bit_q <= reg_wdata[`BIT_POWER_ON];
      end
      osc_run_q <= wr_enable ? reg_wdata[`BIT_POWER_ON] : power_on_bit_q; // RQ4
    end
  end

  // Hardware stop after count or single shot ends measurement
  assign halt_now = meas_done && run_q == RUN_ACTIVE &&
                    ((mode_first_q[`BIT_STOP_COUNT] && iter_q == ITER_LAST) ||
                     mode_first_q[`BIT_SINGLE_SHOT]);

  // Flicker and light enables; a software set wins over a hardware stop
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flicker_enable_q <= 1'b0;
      light_measure_enable_q <= 1'b0;
    end else if (wr_enable) begin
      if (!reg_wdata[`BIT_POWER_ON]) begin
        flicker_enable_q <= 1'b0; // RQ5
        light_measure_enable_q <= 1'b0; // RQ5
      end else begin
        flicker_enable_q <= reg_wdata[`BIT_FLICKER_EN]; // RQ2
        light_measure_enable_q <= reg_wdata[`BIT_LIGHT_EN]; // RQ3
      end
    end else if (halt_now) begin
      flicker_enable_q <= 1'b0; // RQ7 RQ9
      light_measure_enable_q <= 1'b0; // RQ7
    end
  end

  // Mode registers, all bits writable
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_first_q <= `RST_MODE_FIRST; // RQ11
      mode_second_q <= `RST_MODE_SECOND; // RQ16
    end else begin
      if (wr_first) begin
        mode_first_q <= reg_wdata;
      end
      if (wr_second) begin
        mode_second_q <= reg_wdata;
      end
    end
  end

  // Run control state
  always_comb begin
    run_d = run_q;
    case (run_q)
      RUN_OFF: begin
        if (osc_run_q && (flicker_enable_q || light_measure_enable_q)) begin
          run_d = RUN_ACTIVE;
        end
      end
      RUN_ACTIVE: begin
        if (!osc_run_q) begin
          run_d = RUN_OFF;
        end else if (halt_now && mode_first_q[`BIT_SINGLE_SHOT]) begin
          run_d = RUN_SLEEP; // RQ9
        end else if (!flicker_enable_q && !light_measure_enable_q) begin
          run_d = RUN_OFF;
        end
      end
      RUN_SLEEP: begin
        if (wr_enable) begin
          run_d = RUN_OFF;
        end
      end
      default: begin
        run_d = RUN_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      run_q <= RUN_OFF;
    end else begin
      run_q <= run_d;
    end
  end

  // Sleep flag: set by single shot end, cleared by enable write; set wins
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sleep_after_irq_q <= 1'b0;
    end else if (halt_now && mode_first_q[`BIT_SINGLE_SHOT]) begin
      sleep_after_irq_q <= 1'b1; // RQ9
    end else if (wr_enable) begin
      sleep_after_irq_q <= 1'b0;
    end
  end

  // Iteration counter for stop after count
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      iter_q <= 8'h00;
    end else if (run_q != RUN_ACTIVE || halt_now) begin
      iter_q <= 8'h00;
    end else if (meas_done) begin
      iter_q <= iter_q + 8'h01; // RQ7
    end
  end

  // Modulator clock divider, one enable pulse per modulator period
  always_ff @(posedge core_clk) begin
    if (!rst_b || !osc_run_q) begin
      mod_div_q <= 5'h00;
    end else if (mod_div_q == MOD_DIV_LAST) begin
      mod_div_q <= 5'h00;
    end else begin
      mod_div_q <= mod_div_q + 5'h01; // RQ18
    end
  end

  assign mod_tick = osc_run_q && (mod_div_q == MOD_DIV_LAST);

  // Sample step: sample_time plus one modulator periods
  always_ff @(posedge core_clk) begin
    if (!rst_b || run_q != RUN_ACTIVE) begin
      step_cnt_q <= 11'h000;
      sample_step_q <= 1'b0;
    end else begin
      sample_step_q <= 1'b0;
      if (mod_tick) begin
        if (step_cnt_q == sample_time) begin
          step_cnt_q <= 11'h000;
          sample_step_q <= 1'b1; // RQ18
        end else begin
          step_cnt_q <= step_cnt_q + 11'h001;
        end
      end
    end
  end

  // Light result scaling datapath
  light_result_scaler #(
    .RESULT_WIDTH(RESULT_WIDTH)
  ) u_scaler (
    .raw_result(raw_result),
    .top_bit(mode_second_q[`TOP_BIT_HI:`TOP_BIT_LO]), // RQ12 RQ16
    .shift_bits(mode_first_q[`SCALE_HI:`SCALE_LO]), // RQ11
    .light_data(scaled_data),
    .scaled(scaled_flag)
  );

  // Latch light data when a light result completes
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      light_data_q <= 16'h0000;
      light_scaled_q <= 1'b0;
    end else if (light_done) begin
      light_data_q <= scaled_data; // RQ11 RQ12
      light_scaled_q <= scaled_flag;
    end
  end

  // Gain step with optional double step down on saturation
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      gain_step_q <= GAIN_STEP_RESET;
    end else if (gain_saturate && gain_step_q != 4'h0) begin
      if (mode_first_q[`BIT_DOUBLE_STEP] && gain_step_q > 4'h1) begin
        gain_step_q <= gain_step_q - 4'h2; // RQ8
      end else begin
        gain_step_q <= gain_step_q - 4'h1;
      end
    end
  end

  // FIFO words pending; new completions set, one emitted per cycle
  always_comb begin
    pending_d = pending_q;
    for (int i = 0; i < 5; i++) begin
      if (pending_q[i] && (pending_q & ((5'h01 << i) - 5'h01)) == 5'h00) begin
        pending_d[i] = 1'b0;
      end
    end
    if (light_done) begin
      pending_d[SLOT_LIGHT] = 1'b1;
      pending_d[SLOT_STATUS] = mode_first_q[`BIT_LIGHT_STATUS] | pending_d[SLOT_STATUS]; // RQ10
    end
    if (flicker_done) begin
      pending_d[SLOT_GAIN] = mode_second_q[`BIT_GAIN_WRITE] | pending_d[SLOT_GAIN]; // RQ15
      pending_d[SLOT_CHECKSUM] = mode_second_q[`BIT_CHECKSUM] | pending_d[SLOT_CHECKSUM]; // RQ14
      pending_d[SLOT_END] = (mode_second_q[`BIT_END_MARKER] && !flicker_endless_repeat) |
                            pending_d[SLOT_END]; // RQ13 RQ17
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pending_q <= 5'h00;
    end else begin
      pending_q <= pending_d;
    end
  end

  // Emit the lowest pending word
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fifo_wr_q <= 1'b0;
      fifo_word_q <= 16'h0000;
    end else begin
      fifo_wr_q <= pending_q != 5'h00;
      if (pending_q[SLOT_LIGHT]) begin
        fifo_word_q <= light_data_q;
      end else if (pending_q[SLOT_STATUS]) begin
        fifo_word_q <= {`TAG_STATUS, 11'h000, light_scaled_q}; // RQ10
      end else if (pending_q[SLOT_GAIN]) begin
        fifo_word_q <= {`TAG_GAIN, 8'h00, gain_step_q}; // RQ15
      end else if (pending_q[SLOT_CHECKSUM]) begin
        fifo_word_q <= {`TAG_CHECKSUM, flicker_checksum}; // RQ14
      end else if (pending_q[SLOT_END]) begin
        fifo_word_q <= {`TAG_END, `END_MARKER_BODY}; // RQ13
      end
    end
  end

  // Read data one cycle after the read strobe, zero elsewhere
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (hit(reg_addr, `OFS_MOD_DISABLE)) begin
        reg_rdata <= {5'b00000, mod_off_q}; // RQ19
      end else if (hit(reg_addr, `OFS_ENABLE)) begin
        reg_rdata <= {1'b0, flicker_enable_q, 4'b0000,
                      light_measure_enable_q, power_on_bit_q}; // RQ19
      end else if (hit(reg_addr, `OFS_MODE_FIRST)) begin
        reg_rdata <= mode_first_q;
      end else if (hit(reg_addr, `OFS_MODE_SECOND)) begin
        reg_rdata <= mode_second_q;
      end else if (hit(reg_addr, `OFS_STATUS)) begin
        reg_rdata <= {sleep_after_irq_q, light_scaled_q, run_q == RUN_ACTIVE,
                      1'b0, gain_step_q};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : light_sensor_measure_control

`default_nettype wire

// >>> light_sensor_consts.svh
// Constants for the light sensor measure control register bank
`ifndef LIGHT_SENSOR_CONSTS_SVH
`define LIGHT_SENSOR_CONSTS_SVH

// Register offsets
`define OFS_MOD_DISABLE 8'h40
`define OFS_ENABLE 8'h80
`define OFS_MODE_FIRST 8'h81
`define OFS_MODE_SECOND 8'h82
`define OFS_STATUS 8'h90

// Reset values
`define RST_MOD_DISABLE 8'h00
`define RST_ENABLE 8'h00
`define RST_MODE_FIRST 8'h04
`define RST_MODE_SECOND 8'h0C

// Writable bit masks
`define MASK_MOD_DISABLE 8'h07
`define MASK_ENABLE 8'h43

// Enable register fields
`define BIT_FLICKER_EN 6
`define BIT_LIGHT_EN 1
`define BIT_POWER_ON 0

// Mode first fields
`define BIT_STOP_COUNT 7
`define BIT_DOUBLE_STEP 6
`define BIT_SINGLE_SHOT 5
`define BIT_LIGHT_STATUS 4
`define SCALE_HI 3
`define SCALE_LO 0

// Mode second fields
`define BIT_END_MARKER 7
`define BIT_CHECKSUM 6
`define BIT_GAIN_WRITE 5
`define TOP_BIT_HI 4
`define TOP_BIT_LO 0

// Light data window width
`define LIGHT_WIDTH 16

// Modulator clock period and core clock period in picoseconds
`define MOD_PERIOD_PS 1388889
`define CORE_PERIOD_PS 50000
`define MOD_PERIOD_CYC (`MOD_PERIOD_PS / `CORE_PERIOD_PS)

// FIFO word tags
`define TAG_LIGHT 4'h1
`define TAG_STATUS 4'h2
`define TAG_GAIN 4'h3
`define TAG_CHECKSUM 4'h4
`define TAG_END 4'hF
`define END_MARKER_BODY 12'hFFF

`endif

// >>> light_sensor_pkg.sv
// Types shared by the light sensor measure control files
package light_sensor_pkg;

  // Measurement run control states
  typedef enum logic [1:0] {
    RUN_OFF,
    RUN_ACTIVE,
    RUN_SLEEP
  } run_state_e;

  // Pending FIFO word slots, emitted lowest index first
  typedef enum logic [2:0] {
    SLOT_LIGHT,
    SLOT_STATUS,
    SLOT_GAIN,
    SLOT_CHECKSUM,
    SLOT_END
  } slot_e;

endpackage : light_sensor_pkg

// >>> light_result_scaler.sv
// Scales the wide internal light result into a 16-bit light data word
`timescale 1ns/1ps
`default_nettype none

module light_result_scaler
  import light_sensor_pkg::*;
#(
  parameter int RESULT_WIDTH = 32
) (
  input wire logic [RESULT_WIDTH-1:0] raw_result,
  input wire logic [4:0] top_bit,
  input wire logic [3:0] shift_bits,
  output logic [15:0] light_data,
  output logic scaled
);

  logic [5:0] base_shift;
  logic [5:0] final_shift;
  logic lead_zero;
  logic [RESULT_WIDTH-1:0] masked;
  logic [RESULT_WIDTH-1:0] shifted;

  // Keep only bits at or below the selected top bit
  always_comb begin
    masked = '0;
    for (int i = 0; i < RESULT_WIDTH; i++) begin
      if (i <= int'(top_bit)) begin
        masked[i] = raw_result[i];
      end
    end
  end

  // Check that the shift_bits leading bits from the top bit down are all zero
  always_comb begin
    lead_zero = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (i < int'(shift_bits) && i <= int'(top_bit)) begin
        if (raw_result[int'(top_bit) - i]) begin
          lead_zero = 1'b0;
        end
      end
    end
  end

  // Unscaled drops low bits to fit the 16-bit window, scaled drops shift_bits fewer low bits, down to no shift at all
  always_comb begin
    base_shift = (top_bit > 5'd15) ? ({1'b0, top_bit} - 6'd15) : 6'd0;
    if (lead_zero && shift_bits != 4'd0) begin
      final_shift = (base_shift > {2'b00, shift_bits}) ?
                    (base_shift - {2'b00, shift_bits}) : 6'd0;
    end else begin
      final_shift = base_shift;
    end
    shifted = masked >> final_shift;
    light_data = shifted[15:0];
    scaled = lead_zero && (shift_bits != 4'd0);
  end

endmodule : light_result_scaler

`default_nettype wire

// >>> light_sensor_measure_control_properties.sv
// Port-level checks for the measure control register bank
`timescale 1ns/1ps
`default_nettype none
`include "light_sensor_consts.svh"

module light_sensor_measure_control_props (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic light_done,
  input wire logic gain_saturate,
  input wire logic osc_run_q,
  input wire logic [2:0] modulator_on_q,
  input wire logic flicker_enable_q,
  input wire logic light_measure_enable_q,
  input wire logic sample_step_q,
  input wire logic [3:0] gain_step_q,
  input wire logic fifo_wr_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Enable register writes
  chk_power_follows_write: assert property (
    reg_wr && reg_addr == `OFS_ENABLE |=> osc_run_q == $past(reg_wdata[0]))
    else $error("power bit not taken from write");
  chk_enables_follow_write: assert property (
    reg_wr && reg_addr == `OFS_ENABLE |=> {flicker_enable_q, light_measure_enable_q} ==
    ($past(reg_wdata[0]) ? {$past(reg_wdata[6]), $past(reg_wdata[1])} : 2'b00))
    else $error("enable bits not taken from write");
  chk_enable_needs_power: assert property (
    flicker_enable_q || light_measure_enable_q |-> osc_run_q)
    else $error("enable set while power off");
  chk_modulators_unpowered: assert property (
    !osc_run_q |=> modulator_on_q == 3'b000)
    else $error("modulator running without power");
  // Data path timing
  chk_light_word_out: assert property (
    light_done |-> ##2 fifo_wr_q)
    else $error("light word not written");
  chk_step_single_pulse: assert property (
    sample_step_q |=> !sample_step_q [*8])
    else $error("sample step pulse too close");
  chk_gain_drop_size: assert property (
    gain_saturate && gain_step_q != 4'h0 |=> ($past(gain_step_q) - gain_step_q) inside {4'h1, 4'h2})
    else $error("gain drop size wrong");
  chk_gain_hold: assert property (
    (!gain_saturate || gain_step_q == 4'h0) |=> $stable(gain_step_q))
    else $error("gain changed without cause");
  // Read data and reserved bits
  chk_read_idle_zero: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_enable_reserved: assert property (
    reg_rd && reg_addr == `OFS_ENABLE |=> (reg_rdata & 8'hBC) == 8'h00)
    else $error("enable reserved bits not zero");
  chk_disable_reserved: assert property (
    reg_rd && reg_addr == `OFS_MOD_DISABLE |=> reg_rdata[7:3] == 5'h00)
    else $error("modulator reserved bits not zero");
endmodule : light_sensor_measure_control_props

bind light_sensor_measure_control light_sensor_measure_control_props chk_u (
  .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .light_done(light_done),
  .gain_saturate(gain_saturate), .osc_run_q(osc_run_q), .modulator_on_q(modulator_on_q),
  .flicker_enable_q(flicker_enable_q), .light_measure_enable_q(light_measure_enable_q),
  .sample_step_q(sample_step_q), .gain_step_q(gain_step_q), .fifo_wr_q(fifo_wr_q)
);
`default_nettype wire

// >>> light_sensor_measure_control_tb.sv
// Self-checking testbench for the measure control register bank
`timescale 1ns/1ps
`default_nettype none
`include "light_sensor_consts.svh"

module light_sensor_measure_control_tb;
  import light_sensor_pkg::*;
  localparam logic [3:0] GAIN_RST = 4'h9;
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp;} row_s;
  logic core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic meas_done = 1'b0, light_done = 1'b0, flicker_done = 1'b0, gain_saturate = 1'b0;
  logic flicker_endless_repeat = 1'b0;
  logic [10:0] sample_time = 11'h001;
  logic [31:0] raw_result = 32'h0000_0000;
  logic [11:0] flicker_checksum = 12'h000;
  logic [7:0] reg_rdata;
  logic [2:0] modulator_on_q;
  logic [3:0] gain_step_q;
  logic [15:0] light_data_q, fifo_word_q;
  logic osc_run_q, flicker_enable_q, light_measure_enable_q, sleep_after_irq_q;
  logic sample_step_q, light_scaled_q, fifo_wr_q;
  int error_cnt = 0;
  int n_checks = 0;
  int n;
  // Write, readback expectation
  row_s rows [8] = '{'{8'h40, 8'hFF, 8'h07}, '{8'h40, 8'h00, 8'h00}, '{8'h80, 8'hFF, 8'h43},
    '{8'h80, 8'h42, 8'h00}, '{8'h81, 8'hA5, 8'hA5}, '{8'h82, 8'hFF, 8'hFF},
    '{8'h41, 8'h5A, 8'h00}, '{8'h83, 8'h5A, 8'h00}};

  // Clock
  always #25 core_clk = ~core_clk;

  light_sensor_measure_control #(.ITER_COUNT(2), .GAIN_STEP_RESET(GAIN_RST)) dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_time(sample_time),
    .flicker_endless_repeat(flicker_endless_repeat), .meas_done(meas_done),
    .light_done(light_done), .flicker_done(flicker_done), .raw_result(raw_result),
    .gain_saturate(gain_saturate), .flicker_checksum(flicker_checksum),
    .osc_run_q(osc_run_q), .modulator_on_q(modulator_on_q),
    .flicker_enable_q(flicker_enable_q), .light_measure_enable_q(light_measure_enable_q),
    .sleep_after_irq_q(sleep_after_irq_q), .sample_step_q(sample_step_q),
    .light_data_q(light_data_q), .light_scaled_q(light_scaled_q),
    .gain_step_q(gain_step_q), .fifo_wr_q(fifo_wr_q), .fifo_word_q(fifo_word_q)
  );

  task automatic conclude();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic cmp_port(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_port

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_port({8'h00, got}, {8'h00, exp});
  endtask : cmp_reg

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    cmp_reg(reg_rdata, exp);
  endtask : rd_chk

  // One-cycle event pulse, returns in the cycle after it
  task automatic pulse(input int k);
    @(posedge core_clk);
    case (k)
      0: meas_done <= 1'b1;
      1: light_done <= 1'b1;
      2: flicker_done <= 1'b1;
      default: gain_saturate <= 1'b1;
    endcase
    @(posedge core_clk);
    {meas_done, light_done, flicker_done, gain_saturate} <= 4'h0;
    @(negedge core_clk);
  endtask : pulse

  task automatic fifo_chk(input logic [15:0] w);
    cmp_port({15'h0000, fifo_wr_q}, 16'h0001);
    cmp_port(fifo_word_q, w);
    @(negedge core_clk);
  endtask : fifo_chk

  // Cycles up to the next sample step pulse, bounded
  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge core_clk);
      c++;
    end while (sample_step_q !== 1'b1 && c < 500);
    if (c >= 500) begin
      error_cnt++;
      conclude();
    end
  endtask : gap

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    cmp_port({12'h000, gain_step_q}, {12'h000, GAIN_RST});
    @(posedge core_clk);
    rst_b <= 1'b1;
    rd_chk(8'h40, 8'h00);
    rd_chk(8'h80, 8'h00);
    rd_chk(8'h81, 8'h04);
    rd_chk(8'h82, 8'h0C);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].rexp);
    end
    // Modulator disables, power set last
    wr(8'h40, 8'h05);
    wr(8'h80, 8'h01);
    repeat (2) @(negedge core_clk);
    cmp_port({13'h0000, modulator_on_q}, 16'h0002);
    // Sample step period, then stop after two iterations
    wr(8'h81, 8'h80);
    wr(8'h80, 8'h43);
    gap(n);
    gap(n);
    cmp_port(16'(n), 16'((1 + 1) * `MOD_PERIOD_CYC));
    pulse(0);
    cmp_port({13'h0, flicker_enable_q, light_measure_enable_q, osc_run_q}, 16'h0007);
    pulse(0);
    cmp_port({13'h0, flicker_enable_q, light_measure_enable_q, osc_run_q}, 16'h0001);
    // Single shot halts into sleep, next enable write wakes
    wr(8'h81, 8'h20);
    wr(8'h80, 8'h43);
    pulse(0);
    cmp_port({14'h0, flicker_enable_q, light_measure_enable_q}, 16'h0000);
    cmp_port({15'h0, sleep_after_irq_q}, 16'h0001);
    wr(8'h80, 8'h43);
    @(negedge core_clk);
    cmp_port({15'h0, sleep_after_irq_q}, 16'h0000);
    // Gain drop by two, then by one
    wr(8'h81, 8'h40);
    pulse(3);
    cmp_port({12'h000, gain_step_q}, 16'h0007);
    wr(8'h81, 8'h00);
    pulse(3);
    cmp_port({12'h000, gain_step_q}, 16'h0006);
    // Light words, unscaled then scaled
    wr(8'h82, 8'hEF);
    wr(8'h81, 8'h10);
    raw_result <= 32'h0000_1234;
    pulse(1);
    cmp_port(light_data_q, 16'h1234);
    cmp_port({15'h0, light_scaled_q}, 16'h0000);
    @(negedge core_clk);
    fifo_chk(16'h1234);
    fifo_chk(16'h2000);
    wr(8'h81, 8'h14);
    raw_result <= 32'h0000_0012;
    pulse(1);
    cmp_port({15'h0, light_scaled_q}, 16'h0001);
    @(negedge core_clk);
    cmp_port({15'h0, fifo_wr_q}, 16'h0001);
    @(negedge core_clk);
    fifo_chk(16'h2001);
    // Flicker trailer words
    @(posedge core_clk);
    flicker_checksum <= 12'hABC;
    pulse(2);
    @(negedge core_clk);
    fifo_chk(16'h3006);
    fifo_chk(16'h4ABC);
    fifo_chk(16'hFFFF);
    @(posedge core_clk);
    flicker_endless_repeat <= 1'b1;
    pulse(2);
    @(negedge core_clk);
    fifo_chk(16'h3006);
    fifo_chk(16'h4ABC);
    cmp_port({15'h0, fifo_wr_q}, 16'h0000);
    // Status readback: active, scaled, gain six
    rd_chk(8'h90, 8'h66);
    // Top bit above the 16-bit window drops low bits, unscaled
    wr(8'h82, 8'h13);
    raw_result <= 32'h0001_2345;
    pulse(1);
    cmp_port(light_data_q, 16'h1234);
    cmp_port({15'h0, light_scaled_q}, 16'h0000);
    // Power off clears both enables
    wr(8'h80, 8'h43);
    wr(8'h80, 8'h42);
    @(negedge core_clk);
    cmp_port({13'h0, flicker_enable_q, light_measure_enable_q, osc_run_q}, 16'h0000);
    // Mid-run reset restores defaults
    wr(8'h81, 8'h55);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_chk(8'h81, 8'h04);
    rd_chk(8'h82, 8'h0C);
    cmp_port({12'h000, gain_step_q}, {12'h000, GAIN_RST});
    conclude();
  end
endmodule : light_sensor_measure_control_tb
`default_nettype wire
